//--- hw/afemc_top.sv
`timescale 1ns/1ps
`include "afemc_consts.svh"

module afemc_top (
    input wire logic clock,
    input wire logic arst_n,
    input wire afemc_pkg::afemc_bus_t bus,
    input wire logic clamp_or_cycle_pin,
    input wire logic sample_sync_pulse,
    output logic [7:0] rdata,
    output afemc_pkg::afemc_pwr_t pwr,
    output afemc_pkg::afemc_sel_t sel,
    output afemc_pkg::afemc_mode_t mode
);
    import afemc_pkg::*;

    afemc_state_t st_reg;
    afemc_state_t st_next;

    function automatic logic is_wr(input afemc_bus_t b, input logic [3:0] off);
        return b.wr && (b.addr == off);
    endfunction

    function automatic logic [1:0] next_colour(input logic [1:0] c);
        return (c == `AFEMC_BLUE) ? `AFEMC_RED : c + 2'h1;
    endfunction

    logic line_mode;
    logic acyc_step;
    logic sample_edge;
    logic [1:0] intm;
    logic [1:0] forced;
    logic [1:0] chan;
    logic cds_on;

    always_comb begin
        st_next = st_reg;
        line_mode = st_reg.power[`AFEMC_PWR_LINE];
        intm = st_reg.mux[`AFEMC_MUX_INTM_HI:`AFEMC_MUX_INTM_LO];
        forced = st_reg.mux[`AFEMC_MUX_FM_HI:`AFEMC_MUX_FM_LO];
        chan = st_reg.setup3[`AFEMC_S3_CHAN_HI:`AFEMC_S3_CHAN_LO];
        cds_on = st_reg.setup1[1];

        // pin synchronisers
        st_next.acyc_s1 = clamp_or_cycle_pin;
        st_next.acyc_s2 = st_reg.acyc_s1;
        st_next.acyc_prev = st_reg.acyc_s2;
        st_next.sample_sync_pulse_s1 = sample_sync_pulse;
        st_next.sample_sync_pulse_s2 = st_reg.sample_sync_pulse_s1;
        st_next.sample_sync_pulse_prev = st_reg.sample_sync_pulse_s2;
        acyc_step = st_reg.mux[`AFEMC_MUX_ACYC] && st_reg.acyc_s2 && !st_reg.acyc_prev;
        sample_edge = st_reg.sample_sync_pulse_prev && !st_reg.sample_sync_pulse_s2;

        // register writes stay live in every power state
        if (is_wr(bus, `AFEMC_OFF_SETUP1)) begin
            st_next.setup1 = bus.wdata;
        end
        if (is_wr(bus, `AFEMC_OFF_SETUP3)) begin
            st_next.setup3 = bus.wdata;
        end
        if (is_wr(bus, `AFEMC_OFF_POWER)) begin
            st_next.power = bus.wdata;
        end
        if (is_wr(bus, `AFEMC_OFF_MUX)) begin
            st_next.mux = bus.wdata;
        end

        // autocycle sequencer, reset write wins over a step
        if (is_wr(bus, `AFEMC_OFF_ACYC_RST)) begin
            st_next.cycle = `AFEMC_RED;
        end else if (acyc_step) begin
            st_next.cycle = next_colour(st_reg.cycle);
        end

        // power control
        if (st_reg.power[`AFEMC_PWR_SELECTIVE_POWERDOWN_SEL]) begin
            st_next.pwr.block_on = ~st_reg.power[`AFEMC_PWR_MASK_HI:`AFEMC_PWR_MASK_LO];
        end else begin
            st_next.pwr.block_on = {4{st_reg.power[`AFEMC_PWR_EN]}};
        end
        st_next.pwr.pga_on[0] = st_reg.power[`AFEMC_PWR_EN] || st_reg.power[`AFEMC_PWR_SELECTIVE_POWERDOWN_SEL];
        st_next.pwr.pga_on[2:1] = line_mode ? 2'b00 : {2{st_next.pwr.pga_on[0]}};

        // input and offset/gain bank selection
        st_next.sel.single_red_path = line_mode;
        if (line_mode) begin
            case ({st_reg.mux[`AFEMC_MUX_FORCE], st_reg.mux[`AFEMC_MUX_ACYC]})
                2'b00: begin
                    st_next.sel.input_sel = intm;
                    st_next.sel.bank_sel = intm;
                end
                2'b01: begin
                    st_next.sel.input_sel = st_next.cycle;
                    st_next.sel.bank_sel = st_next.cycle;
                end
                2'b10: begin
                    st_next.sel.input_sel = forced;
                    st_next.sel.bank_sel = intm;
                end
                default: begin
                    st_next.sel.input_sel = forced;
                    st_next.sel.bank_sel = st_next.cycle;
                end
            endcase
        end else begin
            st_next.sel.input_sel = chan;
            st_next.sel.bank_sel = chan;
        end

        // sample point and ratio measurement
        st_next.sel.sample_take = sample_edge;
        if (sample_edge) begin
            st_next.count = 8'h00;
            st_next.period = st_reg.count + 8'h01;
        end else if (st_reg.count != 8'hff) begin
            st_next.count = st_reg.count + 8'h01;
        end

        // operating mode from setup one, setup three and the measured ratio
        st_next.mode = MODE_NONE;
        case (st_reg.setup1)
            `AFEMC_S1_PIX_CDS, `AFEMC_S1_PIX_NOCDS: begin
                if (st_reg.period == `AFEMC_RATIO_STD) begin
                    st_next.mode = MODE_1;
                end else if (st_reg.period >= `AFEMC_RATIO_SLOW_MIN && !st_reg.period[0]) begin
                    st_next.mode = MODE_5;
                end
            end
            `AFEMC_S1_MONO_CDS, `AFEMC_S1_MONO_NOCDS: begin
                if (st_reg.period == `AFEMC_RATIO_STD) begin
                    st_next.mode = MODE_2;
                end else if (st_reg.period == `AFEMC_RATIO_FAST &&
                        (!cds_on || st_reg.setup3[`AFEMC_S3_CDSREF_HI:`AFEMC_S3_CDSREF_LO] == 2'h0)) begin
                    st_next.mode = MODE_3;
                end else if (st_reg.period >= `AFEMC_RATIO_SLOW_MIN && !st_reg.period[0]) begin
                    st_next.mode = MODE_6;
                end
            end
            `AFEMC_S1_MAXSPEED: begin
                if (st_reg.period == `AFEMC_RATIO_MAX) begin
                    st_next.mode = MODE_4;
                end
            end
            default: st_next.mode = MODE_NONE;
        endcase

        // read port, answer one cycle after the strobe
        st_next.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `AFEMC_OFF_SETUP1: st_next.rdata = st_reg.setup1;
                `AFEMC_OFF_SETUP3: st_next.rdata = st_reg.setup3;
                `AFEMC_OFF_POWER: st_next.rdata = st_reg.power;
                `AFEMC_OFF_MUX: st_next.rdata = st_reg.mux;
                `AFEMC_OFF_STATUS: st_next.rdata = {st_reg.cycle, 3'h0, st_reg.mode};
                `AFEMC_OFF_PERIOD: st_next.rdata = st_reg.period;
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.setup1 <= `AFEMC_RST_SETUP1;
            st_reg.setup3 <= `AFEMC_RST_SETUP3;
            st_reg.power <= `AFEMC_RST_POWER;
            st_reg.mux <= `AFEMC_RST_MUX;
            st_reg.mode <= MODE_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign pwr = st_reg.pwr;
    assign sel = st_reg.sel;
    assign mode = st_reg.mode;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_pin_rise;
        st_reg.mux[`AFEMC_MUX_ACYC] && st_reg.acyc_s2 && !st_reg.acyc_prev && !is_wr(bus, `AFEMC_OFF_ACYC_RST);
    endsequence

    sequence s_sample_sync_pulse_fall;
        !sample_sync_pulse ##1 sample_sync_pulse ##1 !sample_sync_pulse;
    endsequence

    sequence s_rd_power;
        bus.rd && bus.addr == `AFEMC_OFF_POWER;
    endsequence

    sequence s_rd_setup1;
        bus.rd && bus.addr == `AFEMC_OFF_SETUP1;
    endsequence

    sequence s_line_cycle_only;
        line_mode && st_reg.mux[`AFEMC_MUX_FORCE:`AFEMC_MUX_ACYC] == 2'b01;
    endsequence

    sequence s_line_force_only;
        line_mode && st_reg.mux[`AFEMC_MUX_FORCE:`AFEMC_MUX_ACYC] == 2'b10;
    endsequence

    full_off_a: assert property (
        !st_reg.power[`AFEMC_PWR_EN] && !st_reg.power[`AFEMC_PWR_SELECTIVE_POWERDOWN_SEL] |=> pwr.block_on == 4'h0 && pwr.pga_on == 3'h0)
        else $error("full power down not applied");
    full_on_a: assert property (
        st_reg.power[`AFEMC_PWR_EN] && !st_reg.power[`AFEMC_PWR_SELECTIVE_POWERDOWN_SEL] && !line_mode |=> pwr.block_on == 4'hf)
        else $error("full power up not applied");
    sel_disable_a: assert property (
        st_reg.power[`AFEMC_PWR_SELECTIVE_POWERDOWN_SEL] |=>
        pwr.block_on == ~$past(st_reg.power[`AFEMC_PWR_MASK_HI:`AFEMC_PWR_MASK_LO]))
        else $error("selective disable mismatch");
    line_pga_a: assert property (
        line_mode |=> pwr.pga_on[2:1] == 2'b00 && sel.single_red_path)
        else $error("line mode left green or blue amp on");
    keep_regs_a: assert property (
        !st_reg.power[`AFEMC_PWR_EN] && is_wr(bus, `AFEMC_OFF_SETUP3) |=> st_reg.setup3 == $past(bus.wdata))
        else $error("write lost in power down");
    mono_chan_a: assert property (
        !line_mode |=> sel.input_sel == $past(chan))
        else $error("mono input not from setup three");
    cycle_step_a: assert property (
        s_pin_rise |=> st_reg.cycle == next_colour($past(st_reg.cycle)))
        else $error("autocycle did not advance");
    cycle_reset_a: assert property (
        is_wr(bus, `AFEMC_OFF_ACYC_RST) |=> st_reg.cycle == `AFEMC_RED)
        else $error("autocycle reset ignored");
    internal_sel_a: assert property (
        line_mode && st_reg.mux[1:0] == 2'b00 |=> sel.input_sel == $past(intm) && sel.bank_sel == $past(intm))
        else $error("internal select not followed");
    force_sel_a: assert property (
        line_mode && st_reg.mux[`AFEMC_MUX_FORCE] |=> sel.input_sel == $past(forced))
        else $error("forced input not followed");
    bank_cycle_a: assert property (
        line_mode && st_reg.mux[`AFEMC_MUX_ACYC] |=> sel.bank_sel == st_reg.cycle)
        else $error("bank does not follow cycle");
    sample_point_a: assert property (
        s_sample_sync_pulse_fall |-> ##3 sel.sample_take ##1 !sel.sample_take)
        else $error("sample strobe misplaced");
    max_mode_a: assert property (
        mode == MODE_4 |-> $past(st_reg.setup1) == `AFEMC_S1_MAXSPEED && $past(st_reg.period) == `AFEMC_RATIO_MAX)
        else $error("mode four without 45 setting");

    // mode decode: mode is registered from the previous cycle's setup and period
    mode_one_a: assert property (
        mode == MODE_1 |-> $past(st_reg.period) == `AFEMC_RATIO_STD &&
        ($past(st_reg.setup1) == `AFEMC_S1_PIX_CDS || $past(st_reg.setup1) == `AFEMC_S1_PIX_NOCDS))
        else $error("mode one decode wrong");
    mode_two_a: assert property (
        mode == MODE_2 |-> $past(st_reg.period) == `AFEMC_RATIO_STD &&
        ($past(st_reg.setup1) == `AFEMC_S1_MONO_CDS || $past(st_reg.setup1) == `AFEMC_S1_MONO_NOCDS))
        else $error("mode two decode wrong");
    mode_three_a: assert property (
        mode == MODE_3 |-> $past(st_reg.period) == `AFEMC_RATIO_FAST &&
        ($past(st_reg.setup1) == `AFEMC_S1_MONO_CDS || $past(st_reg.setup1) == `AFEMC_S1_MONO_NOCDS) &&
        (!$past(cds_on) || $past(st_reg.setup3[`AFEMC_S3_CDSREF_HI:`AFEMC_S3_CDSREF_LO]) == 2'h0))
        else $error("mode three decode wrong");
    mode_slow_a: assert property (
        mode == MODE_5 || mode == MODE_6 |->
        $past(st_reg.period) >= `AFEMC_RATIO_SLOW_MIN && !$past(st_reg.period[0]))
        else $error("slow mode with odd or short ratio");

    // read port returns the stored contents in any power state
    rd_power_a: assert property (
        s_rd_power |=> rdata == $past(st_reg.power))
        else $error("power register read back wrong");
    rd_setup_a: assert property (
        s_rd_setup1 |=> rdata == $past(st_reg.setup1))
        else $error("setup one read back wrong");

    // selection details
    input_cycle_a: assert property (
        s_line_cycle_only |=> sel.input_sel == st_reg.cycle)
        else $error("input mux does not follow cycle");
    bank_internal_a: assert property (
        s_line_force_only |=> sel.bank_sel == $past(intm))
        else $error("bank does not follow colour select");
    cycle_hold_a: assert property (
        !acyc_step && !is_wr(bus, `AFEMC_OFF_ACYC_RST) |=> $stable(st_reg.cycle))
        else $error("autocycle moved without a pulse");
    single_off_a: assert property (
        !line_mode |=> !sel.single_red_path)
        else $error("single red path outside line mode");
    pga_red_a: assert property (
        st_reg.power[`AFEMC_PWR_SELECTIVE_POWERDOWN_SEL] |=> pwr.pga_on[0])
        else $error("red amp off in selective mode");
    sample_once_a: assert property (
        sel.sample_take |=> !sel.sample_take)
        else $error("sample strobe longer than one cycle");

endmodule // afemc_top

//--- pkg/afemc_consts.svh
`ifndef AFEMC_CONSTS_SVH
`define AFEMC_CONSTS_SVH

// register offsets on the plain register port
`define AFEMC_ADDR_W 4
`define AFEMC_OFF_SETUP1 4'h1
`define AFEMC_OFF_SETUP3 4'h3
`define AFEMC_OFF_POWER 4'h8
`define AFEMC_OFF_MUX 4'h9
`define AFEMC_OFF_ACYC_RST 4'ha
`define AFEMC_OFF_STATUS 4'hb
`define AFEMC_OFF_PERIOD 4'hc

// reset values
`define AFEMC_RST_SETUP1 8'h00
`define AFEMC_RST_SETUP3 8'h00
`define AFEMC_RST_POWER 8'h00
`define AFEMC_RST_MUX 8'h00

// power register fields
`define AFEMC_PWR_EN 0
`define AFEMC_PWR_SELECTIVE_POWERDOWN_SEL 1
`define AFEMC_PWR_MASK_LO 2
`define AFEMC_PWR_MASK_HI 5
`define AFEMC_PWR_LINE 6

// mux register fields
`define AFEMC_MUX_ACYC 0
`define AFEMC_MUX_FORCE 1
`define AFEMC_MUX_FM_LO 2
`define AFEMC_MUX_FM_HI 3
`define AFEMC_MUX_INTM_LO 4
`define AFEMC_MUX_INTM_HI 5

// setup register three fields
`define AFEMC_S3_CHAN_LO 6
`define AFEMC_S3_CHAN_HI 7
`define AFEMC_S3_CDSREF_LO 4
`define AFEMC_S3_CDSREF_HI 5

// setup register one contents per mode
`define AFEMC_S1_PIX_CDS 8'h03
`define AFEMC_S1_PIX_NOCDS 8'h01
`define AFEMC_S1_MONO_CDS 8'h07
`define AFEMC_S1_MONO_NOCDS 8'h05
`define AFEMC_S1_MAXSPEED 8'h45

// master clock to sample pulse ratios
`define AFEMC_RATIO_STD 8'h06
`define AFEMC_RATIO_FAST 8'h03
`define AFEMC_RATIO_MAX 8'h02
`define AFEMC_RATIO_SLOW_MIN 8'h08

// colour codes
`define AFEMC_RED 2'h0
`define AFEMC_GREEN 2'h1
`define AFEMC_BLUE 2'h2

`endif

//--- pkg/afemc_pkg.sv
package afemc_pkg;

    typedef enum logic [2:0] {
        MODE_NONE, MODE_1, MODE_2, MODE_3, MODE_4, MODE_5, MODE_6
    } afemc_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } afemc_bus_t;

    typedef struct packed {
        logic [3:0] block_on;
        logic [2:0] pga_on;
    } afemc_pwr_t;

    typedef struct packed {
        logic [1:0] input_sel;
        logic [1:0] bank_sel;
        logic single_red_path;
        logic sample_take;
    } afemc_sel_t;

    typedef struct packed {
        logic acyc_s1;
        logic acyc_s2;
        logic acyc_prev;
        logic sample_sync_pulse_s1;
        logic sample_sync_pulse_s2;
        logic sample_sync_pulse_prev;
        logic [7:0] setup1;
        logic [7:0] setup3;
        logic [7:0] power;
        logic [7:0] mux;
        logic [1:0] cycle;
        logic [7:0] count;
        logic [7:0] period;
        afemc_mode_t mode;
        afemc_pwr_t pwr;
        afemc_sel_t sel;
        logic [7:0] rdata;
    } afemc_state_t;

endpackage

//--- test/afemc_ctrl_model.sv
`timescale 1ns/1ps

module afemc_ctrl_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] ratio,
    input wire logic cycle_go,
    output logic sample_sync_pulse,
    output logic clamp_or_cycle_pin
);
    logic [7:0] cnt_reg;
    logic [1:0] hold_reg;

    // one-clock pulse every ratio clocks, none while ratio is 0
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 8'h00;
            sample_sync_pulse <= 1'b0;
        end else if (ratio == 8'h00) begin
            cnt_reg <= 8'h00;
            sample_sync_pulse <= 1'b0;
        end else if (cnt_reg >= ratio - 8'h01) begin
            cnt_reg <= 8'h00;
            sample_sync_pulse <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            sample_sync_pulse <= 1'b0;
        end
    end

    // cycle pin held three clocks so the sync flops see it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg <= 2'h0;
        end else if (cycle_go) begin
            hold_reg <= 2'h3;
        end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end
    end

    assign clamp_or_cycle_pin = (hold_reg != 2'h0);
endmodule // afemc_ctrl_model

//--- test/afemc_mode_channel_control_tb.sv
`timescale 1ns/1ps

module afemc_mode_channel_control_tb;
    import afemc_pkg::*;

    typedef struct packed {
        logic [7:0] pw, mx, s3;
        logic [3:0] blk;
        logic [2:0] pga;
        logic [1:0] in, bk;
    } afemc_prow_t;

    typedef struct packed {
        logic [7:0] s1, rt, s3;
        afemc_mode_t md;
    } afemc_mrow_t;

    logic clock = 1'b0;
    logic arst_n = 1'b0;
    afemc_bus_t bus = '0;
    logic [7:0] ratio = 8'h06;
    logic cycle_go = 1'b0;
    logic cyc_pin;
    logic smp_pulse;
    logic [7:0] rdata;
    afemc_pwr_t pwr;
    afemc_sel_t sel;
    afemc_mode_t mode;
    int error_cnt = 0;
    int comparisons = 0;

    afemc_prow_t prows [7] = '{
        '{8'h00, 8'h00, 8'h80, 4'h0, 3'h0, 2'h2, 2'h2},
        '{8'h01, 8'h00, 8'h40, 4'hf, 3'h7, 2'h1, 2'h1},
        '{8'h16, 8'h00, 8'h00, 4'ha, 3'h7, 2'h0, 2'h0},
        '{8'h3f, 8'h00, 8'h80, 4'h0, 3'h7, 2'h2, 2'h2},
        '{8'h41, 8'h20, 8'h00, 4'hf, 3'h1, 2'h2, 2'h2},
        '{8'h41, 8'h26, 8'h80, 4'hf, 3'h1, 2'h1, 2'h2},
        '{8'h41, 8'h1a, 8'h00, 4'hf, 3'h1, 2'h2, 2'h1}};

    afemc_mrow_t mrows [9] = '{
        '{8'h03, 8'h06, 8'h00, MODE_1}, '{8'h01, 8'h06, 8'h00, MODE_1},
        '{8'h07, 8'h06, 8'h00, MODE_2}, '{8'h07, 8'h03, 8'h00, MODE_3},
        '{8'h05, 8'h03, 8'h30, MODE_3}, '{8'h07, 8'h03, 8'h30, MODE_NONE},
        '{8'h45, 8'h02, 8'h00, MODE_4}, '{8'h01, 8'h08, 8'h00, MODE_5},
        '{8'h05, 8'h0a, 8'h00, MODE_6}};

    always #2.5 clock = ~clock;

    afemc_ctrl_model model_u (
        .clock(clock),
        .arst_n(arst_n),
        .ratio(ratio),
        .cycle_go(cycle_go),
        .sample_sync_pulse(smp_pulse),
        .clamp_or_cycle_pin(cyc_pin)
    );

    afemc_top dut_u (
        .clock(clock),
        .arst_n(arst_n),
        .bus(bus),
        .clamp_or_cycle_pin(cyc_pin),
        .sample_sync_pulse(smp_pulse),
        .rdata(rdata),
        .pwr(pwr),
        .sel(sel),
        .mode(mode)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    task automatic pulse();
        @(posedge clock);
        cycle_go <= 1'b1;
        @(posedge clock);
        cycle_go <= 1'b0;
        cyc(6);
        #1;
    endtask

    task automatic end_sim();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end

    initial begin
        cyc(4);
        arst_n <= 1'b1;
        foreach (prows[i]) begin
            wr(4'h8, prows[i].pw);
            wr(4'h9, prows[i].mx);
            wr(4'h3, prows[i].s3);
            cyc(3);
            #1;
            check({4'h0, pwr.block_on}, {4'h0, prows[i].blk});
            check({5'h0, pwr.pga_on}, {5'h0, prows[i].pga});
            check({6'h0, sel.input_sel}, {6'h0, prows[i].in});
            check({6'h0, sel.bank_sel}, {6'h0, prows[i].bk});
            check({7'h0, sel.single_red_path}, {7'h0, prows[i].pw[6]});
        end
        foreach (mrows[i]) begin
            wr(4'h1, mrows[i].s1);
            wr(4'h3, mrows[i].s3);
            ratio <= mrows[i].rt;
            cyc(40);
            #1;
            check({5'h0, mode}, {5'h0, mrows[i].md});
        end
        rd(4'hb, 8'h06);
        rd(4'hc, 8'h0a);
        ratio <= 8'h06;
        do begin
            @(posedge clock);
            #1;
        end while (smp_pulse !== 1'b1);
        cyc(4);
        #1;
        check({7'h0, sel.sample_take}, 8'h01);
        cyc(1);
        #1;
        check({7'h0, sel.sample_take}, 8'h00);
        wr(4'h8, 8'h41);
        wr(4'h9, 8'h01);
        wr(4'ha, 8'h00);
        for (int k = 1; k <= 3; k++) begin
            pulse();
            check({6'h0, sel.input_sel}, 8'(k % 3));
            check({6'h0, sel.bank_sel}, 8'(k % 3));
        end
        wr(4'h9, 8'h0b);
        wr(4'ha, 8'h00);
        pulse();
        check({6'h0, sel.input_sel}, 8'h02);
        check({6'h0, sel.bank_sel}, 8'h01);
        wr(4'ha, 8'hff);
        cyc(3);
        #1;
        check({6'h0, sel.bank_sel}, 8'h00);
        wr(4'h8, 8'h00);
        wr(4'h1, 8'h5a);
        rd(4'h1, 8'h5a);
        rd(4'h9, 8'h0b);
        rd(4'h5, 8'h00);
        rd(4'hc, 8'h06);
        // reset in mid-run: everything back to power down
        @(posedge clock);
        arst_n <= 1'b0;
        cyc(2);
        #1;
        check({1'b0, pwr}, 8'h00);
        check({2'h0, sel}, 8'h00);
        check({5'h0, mode}, 8'h00);
        check(rdata, 8'h00);
        @(posedge clock);
        arst_n <= 1'b1;
        rd(4'h8, 8'h00);
        rd(4'h1, 8'h00);
        end_sim();
    end
endmodule // afemc_mode_channel_control_tb
